// file: rtl/sdisq_pkg.sv
/*
 package of constants for the serial transceiver sequence controller.
 assumes a single 100 MHz core_clk that also stands for the reconfiguration-port clock.
*/
// Behaviour
// - separate rx and tx sequencers, each running independently of the other
// - sequence on power-up, on reset inputs and on a video standard change while idle
// - a reset-done or access phase that times out is retried several times, then failure is signalled
// - tx waits for reset-done to fall then rise again within a timeout
// - done high while idle, low from sequence start to its end
// - success raises done; failure keeps done low and raises fail
// - fail code is meaningful only while fail is high
// - reset-done timeout after starting a reset gives code 0
// - arbiter grants the shared reconfiguration port to one sequencer at a time
// - no grant within timeout ends sequence with code 1
// - access without completion is retried, then fails with code 2
// - unsupported pll output divider request fails with code 3
// - after failure only a full reset request is honoured
// - full reset attempts complete reset; if it fails fail stays high
// - fixed clock frequency parameter, default 27000000 hz, times the rate measure
// - fail code three bits; status outputs on the reconfiguration clock
package sdisq_pkg;
   localparam int unsigned CODE_W           = 3;
   localparam logic [2:0]  CODE_RST_TIMEOUT = 3'h0;
   localparam logic [2:0]  CODE_GNT_TIMEOUT = 3'h1;
   localparam logic [2:0]  CODE_ACC_TIMEOUT = 3'h2;
   localparam logic [2:0]  CODE_BAD_DIV     = 3'h3;
   localparam int unsigned MODE_W           = 3;
   localparam int unsigned DIV_W            = 3;
   localparam logic [2:0]  DIV_MAX_OK       = 3'h4;
   localparam int unsigned RETRIES          = 3;
   localparam int unsigned RETRY_W          = 2;
   localparam int unsigned RESET_PULSE_NS   = 100;
   localparam int unsigned RESET_TIMEOUT_NS = 1000000;
   localparam int unsigned GNT_TIMEOUT_NS   = 10000;
   localparam int unsigned ACC_TIMEOUT_NS   = 1000;
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned TMR_W            = 24;
   localparam int unsigned FIXED_CLOCK_HZ   = 27000000;
   localparam logic [23:0] TMR_ZERO         = 24'h00_0000;
endpackage : sdisq_pkg

// file: rtl/sdisq_seq.sv
/*
 one transceiver half sequencer: reset, wait reset-done, optional divider
 write over the shared reconfiguration port, done/fail status.
 assumes the arbiter grant and access completion arrive on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sdisq_seq #(
   parameter int unsigned RECONFIG_CLK_PERIOD_NS = sdisq_pkg::CLK_PERIOD_NS,
   parameter int unsigned RESET_PULSE_CYC        = 10,
   parameter int unsigned RESET_TIMEOUT_CYC      = 100000,
   parameter int unsigned GNT_TIMEOUT_CYC        = 1000,
   parameter int unsigned ACC_TIMEOUT_CYC        = 100
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   input  wire logic                          full_reset,
   input  wire logic                          mode_change,
   input  wire logic [sdisq_pkg::DIV_W-1:0]   pll_divider,
   input  wire logic                          reset_done,
   input  wire logic                          port_grant,
   input  wire logic                          reconfig_access_complete,
   output logic                               xcvr_reset,
   output logic                               port_request,
   output logic                               port_access,
   output logic [sdisq_pkg::DIV_W-1:0]        port_wdata,
   output logic                               change_done,
   output logic                               change_fail,
   output logic [sdisq_pkg::CODE_W-1:0]       change_fail_code
);
   typedef enum logic [2:0] {
      S_IDLE, S_RESET, S_RDONE_LOW, S_RDONE_HIGH, S_REQ, S_ACC, S_FAILED
   } sdisq_state_e;

   localparam logic [23:0] PULSE_C = 24'(RESET_PULSE_CYC);
   localparam logic [23:0] RTO_C   = 24'(RESET_TIMEOUT_CYC);
   localparam logic [23:0] GTO_C   = 24'(GNT_TIMEOUT_CYC);
   localparam logic [23:0] ATO_C   = 24'(ACC_TIMEOUT_CYC);
   localparam logic [1:0]  RETRY_C = 2'(sdisq_pkg::RETRIES);

   sdisq_state_e                    state_q, state_d;
   logic [sdisq_pkg::TMR_W-1:0]     tmr_q, tmr_d;
   logic [sdisq_pkg::RETRY_W-1:0]   try_q, try_d;
   logic                            chg_q, chg_d;
   logic [sdisq_pkg::DIV_W-1:0]     div_q, div_d;
   logic                            rst_o_q, rst_o_d, req_q, req_d, acc_q, acc_d;
   logic                            done_q, done_d, fail_q, fail_d;
   logic [sdisq_pkg::CODE_W-1:0]    code_q, code_d;

   always_comb begin
      state_d = state_q;
      tmr_d   = tmr_q + 24'h00_0001;
      try_d   = try_q;
      chg_d   = chg_q;
      div_d   = div_q;
      rst_o_d = 1'b0;
      req_d   = req_q;
      acc_d   = 1'b0;
      done_d  = done_q;
      fail_d  = fail_q;
      code_d  = code_q;
      unique case (state_q)
         S_IDLE: begin
            if (full_reset) begin
               state_d = S_RESET;
               chg_d   = 1'b0;
               try_d   = '0;
               tmr_d   = sdisq_pkg::TMR_ZERO;
               done_d  = 1'b0;
            end else if (mode_change) begin
               state_d = S_RESET;
               chg_d   = 1'b1;
               div_d   = pll_divider;
               try_d   = '0;
               tmr_d   = sdisq_pkg::TMR_ZERO;
               done_d  = 1'b0;
            end
         end
         S_RESET: begin
            rst_o_d = 1'b1;
            code_d  = sdisq_pkg::CODE_RST_TIMEOUT;
            if (tmr_q >= PULSE_C) begin
               rst_o_d = 1'b0;
               state_d = S_RDONE_LOW;
               tmr_d   = sdisq_pkg::TMR_ZERO;
            end
         end
         S_RDONE_LOW, S_RDONE_HIGH: begin
            if (state_q == S_RDONE_LOW && !reset_done) begin
               state_d = S_RDONE_HIGH;
            end else if (state_q == S_RDONE_HIGH && reset_done) begin
               tmr_d = sdisq_pkg::TMR_ZERO;
               try_d = '0;
               if (!chg_q) begin
                  state_d = S_IDLE;
                  done_d  = 1'b1;
                  fail_d  = 1'b0;
               end else if (div_q > sdisq_pkg::DIV_MAX_OK) begin
                  state_d = S_FAILED;
                  code_d  = sdisq_pkg::CODE_BAD_DIV;
                  fail_d  = 1'b1;
               end else begin
                  state_d = S_REQ;
                  req_d   = 1'b1;
               end
            end
            if (tmr_q >= RTO_C) begin
               tmr_d = sdisq_pkg::TMR_ZERO;
               if (try_q == RETRY_C) begin
                  state_d = S_FAILED;
                  code_d  = sdisq_pkg::CODE_RST_TIMEOUT;
                  fail_d  = 1'b1;
               end else begin
                  state_d = S_RESET;
                  try_d   = try_q + 2'h1;
               end
            end
         end
         S_REQ: begin
            if (port_grant) begin
               state_d = S_ACC;
               acc_d   = 1'b1;
               tmr_d   = sdisq_pkg::TMR_ZERO;
            end else if (tmr_q >= GTO_C) begin
               state_d = S_FAILED;
               req_d   = 1'b0;
               code_d  = sdisq_pkg::CODE_GNT_TIMEOUT;
               fail_d  = 1'b1;
            end
         end
         S_ACC: begin
            if (reconfig_access_complete) begin
               state_d = S_IDLE;
               req_d   = 1'b0;
               done_d  = 1'b1;
            end else if (tmr_q >= ATO_C) begin
               tmr_d = sdisq_pkg::TMR_ZERO;
               if (try_q == RETRY_C) begin
                  state_d = S_FAILED;
                  req_d   = 1'b0;
                  code_d  = sdisq_pkg::CODE_ACC_TIMEOUT;
                  fail_d  = 1'b1;
               end else begin
                  acc_d = 1'b1;
                  try_d = try_q + 2'h1;
               end
            end
         end
         S_FAILED: begin
            if (full_reset) begin
               state_d = S_RESET;
               chg_d   = 1'b0;
               try_d   = '0;
               tmr_d   = sdisq_pkg::TMR_ZERO;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= S_RESET;
         tmr_q   <= sdisq_pkg::TMR_ZERO;
         try_q   <= '0;
         chg_q   <= 1'b0;
         div_q   <= '0;
         rst_o_q <= 1'b0;
         req_q   <= 1'b0;
         acc_q   <= 1'b0;
         done_q  <= 1'b0;
         fail_q  <= 1'b0;
         code_q  <= sdisq_pkg::CODE_RST_TIMEOUT;
      end else begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
         try_q   <= try_d;
         chg_q   <= chg_d;
         div_q   <= div_d;
         rst_o_q <= rst_o_d;
         req_q   <= req_d;
         acc_q   <= acc_d;
         done_q  <= done_d;
         fail_q  <= fail_d;
         code_q  <= code_d;
      end
   end

   assign xcvr_reset       = rst_o_q;
   assign port_request     = req_q;
   assign port_access      = acc_q;
   assign port_wdata       = div_q;
   assign change_done      = done_q;
   assign change_fail      = fail_q;
   assign change_fail_code = code_q;
endmodule : sdisq_seq
`default_nettype wire

// file: rtl/sdisq_top.sv
/*
 rx and tx sequencers plus the reconfiguration port arbiter.
 assumes transceiver status inputs synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sdisq_top #(
   parameter int unsigned RECONFIG_CLK_PERIOD_NS   = sdisq_pkg::CLK_PERIOD_NS,
   parameter int unsigned FIXED_CLOCK_FREQUENCY_HZ = sdisq_pkg::FIXED_CLOCK_HZ,
   parameter int unsigned RESET_TIMEOUT_CYC        =
      sdisq_pkg::RESET_TIMEOUT_NS / RECONFIG_CLK_PERIOD_NS
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   input  wire logic                          rx_full_reset,
   input  wire logic                          rx_mode_change,
   input  wire logic [sdisq_pkg::DIV_W-1:0]   rx_pll_divider,
   input  wire logic                          rx_reset_done,
   input  wire logic                          tx_full_reset,
   input  wire logic                          tx_mode_change,
   input  wire logic [sdisq_pkg::DIV_W-1:0]   tx_pll_divider,
   input  wire logic                          tx_reset_done,
   input  wire logic                          reconfig_access_complete,
   input  wire logic                          rx_recovered_tick,
   output logic                               rx_xcvr_reset,
   output logic                               tx_xcvr_reset,
   output logic                               port_access,
   output logic                               port_sel_tx,
   output logic [sdisq_pkg::DIV_W-1:0]        port_wdata,
   output logic [23:0]                        rx_rate_count,
   output logic                               rx_change_done,
   output logic                               rx_change_fail,
   output logic [sdisq_pkg::CODE_W-1:0]       rx_change_fail_code,
   output logic                               tx_change_done,
   output logic                               tx_change_fail,
   output logic [sdisq_pkg::CODE_W-1:0]       tx_change_fail_code
);
   localparam int unsigned PULSE_CYC =
      (sdisq_pkg::RESET_PULSE_NS + RECONFIG_CLK_PERIOD_NS - 1) / RECONFIG_CLK_PERIOD_NS;
   localparam int unsigned GNT_CYC = sdisq_pkg::GNT_TIMEOUT_NS / RECONFIG_CLK_PERIOD_NS;
   localparam int unsigned ACC_CYC = sdisq_pkg::ACC_TIMEOUT_NS / RECONFIG_CLK_PERIOD_NS;
   localparam logic [23:0] WIN_C = 24'(FIXED_CLOCK_FREQUENCY_HZ / 1000);

   logic [1:0]                      req, acc, gnt;
   logic [sdisq_pkg::DIV_W-1:0]     wd [2];
   logic                            own_q, own_d, busy_q, busy_d;
   logic                            pacc_q, pacc_d;
   logic [sdisq_pkg::DIV_W-1:0]     pwd_q, pwd_d;
   logic [23:0]                     win_q, win_d, cnt_q, cnt_d, rate_q, rate_d;

   sdisq_seq #(.RECONFIG_CLK_PERIOD_NS(RECONFIG_CLK_PERIOD_NS), .RESET_PULSE_CYC(PULSE_CYC),
      .RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC), .GNT_TIMEOUT_CYC(GNT_CYC),
      .ACC_TIMEOUT_CYC(ACC_CYC)) u_rx (
      .core_clk(core_clk), .rst(rst), .full_reset(rx_full_reset),
      .mode_change(rx_mode_change), .pll_divider(rx_pll_divider),
      .reset_done(rx_reset_done), .port_grant(gnt[0]),
      .reconfig_access_complete(reconfig_access_complete && !own_q),
      .xcvr_reset(rx_xcvr_reset), .port_request(req[0]), .port_access(acc[0]),
      .port_wdata(wd[0]), .change_done(rx_change_done), .change_fail(rx_change_fail),
      .change_fail_code(rx_change_fail_code));

   sdisq_seq #(.RECONFIG_CLK_PERIOD_NS(RECONFIG_CLK_PERIOD_NS), .RESET_PULSE_CYC(PULSE_CYC),
      .RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC), .GNT_TIMEOUT_CYC(GNT_CYC),
      .ACC_TIMEOUT_CYC(ACC_CYC)) u_tx (
      .core_clk(core_clk), .rst(rst), .full_reset(tx_full_reset),
      .mode_change(tx_mode_change), .pll_divider(tx_pll_divider),
      .reset_done(tx_reset_done), .port_grant(gnt[1]),
      .reconfig_access_complete(reconfig_access_complete && own_q),
      .xcvr_reset(tx_xcvr_reset), .port_request(req[1]), .port_access(acc[1]),
      .port_wdata(wd[1]), .change_done(tx_change_done), .change_fail(tx_change_fail),
      .change_fail_code(tx_change_fail_code));

   assign gnt[0] = busy_q && !own_q;
   assign gnt[1] = busy_q && own_q;

   always_comb begin
      own_d  = own_q;
      busy_d = busy_q;
      if (busy_q && !req[own_q]) begin
         busy_d = 1'b0;
      end else if (!busy_q && (req[0] || req[1])) begin
         busy_d = 1'b1;
         own_d  = !req[0];
      end
      pacc_d = acc[own_q] && busy_q;
      pwd_d  = wd[own_q];
      win_d  = win_q + 24'h00_0001;
      cnt_d  = cnt_q + {23'h00_0000, rx_recovered_tick};
      rate_d = rate_q;
      // window of exactly WIN_C cycles; a tick on the wrap edge opens the next count
      if (win_q >= WIN_C - 24'h00_0001) begin
         win_d  = sdisq_pkg::TMR_ZERO;
         cnt_d  = {23'h00_0000, rx_recovered_tick};
         rate_d = cnt_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         own_q  <= 1'b0;
         busy_q <= 1'b0;
         pacc_q <= 1'b0;
         pwd_q  <= '0;
         win_q  <= sdisq_pkg::TMR_ZERO;
         cnt_q  <= sdisq_pkg::TMR_ZERO;
         rate_q <= sdisq_pkg::TMR_ZERO;
      end else begin
         own_q  <= own_d;
         busy_q <= busy_d;
         pacc_q <= pacc_d;
         pwd_q  <= pwd_d;
         win_q  <= win_d;
         cnt_q  <= cnt_d;
         rate_q <= rate_d;
      end
   end

   assign port_access   = pacc_q;
   assign port_sel_tx   = own_q;
   assign port_wdata    = pwd_q;
   assign rx_rate_count = rate_q;
endmodule : sdisq_top
`default_nettype wire

// file: test/sdisq_xcvr_model.sv
/*
 transceiver stand-in: reset-done and reconfiguration access completion.
 assumes sdisq_top outputs on core_clk; dead inputs suppress the answers.
*/
`timescale 1ns/100ps
`default_nettype none
module sdisq_xcvr_model #(
   parameter int unsigned DLY = 5
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic rx_xcvr_reset,
   input  wire logic tx_xcvr_reset,
   input  wire logic port_access,
   input  wire logic rx_dead,
   input  wire logic tx_dead,
   input  wire logic acc_dead,
   output logic      rx_reset_done,
   output logic      tx_reset_done,
   output logic      reconfig_access_complete
);
   int unsigned rx_cnt = 0;
   int unsigned tx_cnt = 0;
   logic [2:0]  acc_sr = 3'h0;
   // reset-done drops under reset, returns DLY cycles after release
   always @(posedge core_clk) begin
      rx_cnt <= (rst || rx_xcvr_reset || rx_dead) ? 0 : ((rx_cnt < DLY) ? rx_cnt + 1 : rx_cnt);
      tx_cnt <= (rst || tx_xcvr_reset || tx_dead) ? 0 : ((tx_cnt < DLY) ? tx_cnt + 1 : tx_cnt);
      acc_sr <= rst ? 3'h0 : {acc_sr[1:0], port_access};
   end
   assign rx_reset_done = (rx_cnt == DLY);
   assign tx_reset_done = (tx_cnt == DLY);
   assign reconfig_access_complete = acc_sr[2] && !acc_dead;
endmodule : sdisq_xcvr_model
`default_nettype wire

// file: test/sdisq_top_chk.sv
/*
 concurrent checks on the sequence controller ports.
 assumes binding into sdisq_top; one clock core_clk, sync reset rst.
*/
`timescale 1ns/100ps
`default_nettype none
module sdisq_top_chk (
   input wire logic                            core_clk,
   input wire logic                            rst,
   input wire logic                            rx_full_reset,
   input wire logic                            rx_mode_change,
   input wire logic                            rx_xcvr_reset,
   input wire logic                            tx_xcvr_reset,
   input wire logic                            tx_reset_done,
   input wire logic                            port_access,
   input wire logic                            rx_change_done,
   input wire logic                            rx_change_fail,
   input wire logic [sdisq_pkg::CODE_W-1:0]    rx_change_fail_code,
   input wire logic                            tx_full_reset,
   input wire logic                            tx_change_done,
   input wire logic                            tx_change_fail
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic rx_fprev_q, rx_hold_q, tx_fprev_q, tx_hold_q;
   // hold marks a settled failure not yet answered by a full reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_fprev_q <= 1'b0;
         rx_hold_q  <= 1'b0;
         tx_fprev_q <= 1'b0;
         tx_hold_q  <= 1'b0;
      end else begin
         rx_fprev_q <= rx_change_fail;
         rx_hold_q  <= !rx_full_reset && (rx_hold_q || (rx_change_fail && !rx_fprev_q));
         tx_fprev_q <= tx_change_fail;
         tx_hold_q  <= !tx_full_reset && (tx_hold_q || (tx_change_fail && !tx_fprev_q));
      end
   end
   AST_RX_EXCL: assert property (!(rx_change_done && rx_change_fail))
      else $error("rx done and fail high together");
   AST_TX_EXCL: assert property (!(tx_change_done && tx_change_fail))
      else $error("tx done and fail high together");
   AST_RX_BUSY: assert property (rx_xcvr_reset |-> !rx_change_done)
      else $error("rx done high during reset pulse");
   AST_TX_BUSY: assert property (tx_xcvr_reset |-> !tx_change_done)
      else $error("tx done high during reset pulse");
   AST_RX_START: assert property (rx_change_done && (rx_mode_change || rx_full_reset) |=>
      !rx_change_done ##1 rx_xcvr_reset) else $error("rx start timing wrong");
   AST_RX_STICKY: assert property (rx_hold_q && !rx_full_reset |=>
      rx_change_fail && !$rose(rx_xcvr_reset)) else $error("rx left failure without reset");
   AST_TX_STICKY: assert property (tx_hold_q && !tx_full_reset |=> tx_change_fail)
      else $error("tx left failure without reset");
   AST_RX_CODE: assert property (rx_hold_q && !rx_full_reset |=> $stable(rx_change_fail_code))
      else $error("rx code moved while failed");
   AST_ACC_PULSE: assert property (port_access |=> !port_access)
      else $error("access strobe longer than one cycle");
   AST_TX_RD: assert property ($rose(tx_change_done) |-> tx_reset_done && !tx_xcvr_reset)
      else $error("tx done without reset-done");
endmodule : sdisq_top_chk
`default_nettype wire
bind sdisq_top sdisq_top_chk u_chk (.core_clk(core_clk), .rst(rst),
   .rx_full_reset(rx_full_reset), .rx_mode_change(rx_mode_change),
   .rx_xcvr_reset(rx_xcvr_reset), .tx_xcvr_reset(tx_xcvr_reset),
   .tx_reset_done(tx_reset_done), .port_access(port_access),
   .rx_change_done(rx_change_done), .rx_change_fail(rx_change_fail),
   .rx_change_fail_code(rx_change_fail_code), .tx_full_reset(tx_full_reset),
   .tx_change_done(tx_change_done), .tx_change_fail(tx_change_fail));

// file: test/sdisq_tb_top.sv
/*
 directed bench for the sequence controller with the transceiver model.
 assumes 100 MHz core_clk, short reset timeout and short rate window.
*/
`timescale 1ns/100ps
`default_nettype none
module sdisq_tb_top;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic       rx_full_reset = 1'b0, rx_mode_change = 1'b0, tx_full_reset = 1'b0;
   logic       tx_mode_change = 1'b0, rx_dead = 1'b0, tx_dead = 1'b0, acc_dead = 1'b0;
   logic [2:0] rx_pll_divider = 3'h0, tx_pll_divider = 3'h0;
   logic [1:0] tk = 2'h0;
   logic       rx_tick = 1'b0, tx_prev = 1'b0;
   wire logic  rx_rd, tx_rd, acc_cmp, rx_xr, tx_xr, port_access, port_sel_tx;
   wire logic  rx_done, rx_fail, tx_done, tx_fail;
   wire logic [2:0]  port_wdata, rx_code, tx_code;
   wire logic [23:0] rx_rate_count;
   int         bad_count = 0, n_tests = 0, tx_rises = 0, r;
   logic [3:0] acc_q[$];
   sdisq_top #(.FIXED_CLOCK_FREQUENCY_HZ(100000), .RESET_TIMEOUT_CYC(50)) dut (
      .core_clk(core_clk), .rst(rst), .rx_full_reset(rx_full_reset),
      .rx_mode_change(rx_mode_change), .rx_pll_divider(rx_pll_divider), .rx_reset_done(rx_rd),
      .tx_full_reset(tx_full_reset), .tx_mode_change(tx_mode_change),
      .tx_pll_divider(tx_pll_divider), .tx_reset_done(tx_rd), .reconfig_access_complete(acc_cmp),
      .rx_recovered_tick(rx_tick), .rx_xcvr_reset(rx_xr), .tx_xcvr_reset(tx_xr),
      .port_access(port_access), .port_sel_tx(port_sel_tx), .port_wdata(port_wdata),
      .rx_rate_count(rx_rate_count), .rx_change_done(rx_done), .rx_change_fail(rx_fail),
      .rx_change_fail_code(rx_code), .tx_change_done(tx_done), .tx_change_fail(tx_fail),
      .tx_change_fail_code(tx_code));
   sdisq_xcvr_model u_xcvr (.core_clk(core_clk), .rst(rst), .rx_xcvr_reset(rx_xr),
      .tx_xcvr_reset(tx_xr), .port_access(port_access), .rx_dead(rx_dead), .tx_dead(tx_dead),
      .acc_dead(acc_dead), .rx_reset_done(rx_rd), .tx_reset_done(tx_rd),
      .reconfig_access_complete(acc_cmp));
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      tk <= tk + 2'h1;
      rx_tick <= (tk == 2'h3);
      if (port_access === 1'b1) acc_q.push_back({port_sel_tx, port_wdata});
      if (tx_xr === 1'b1 && tx_prev !== 1'b1) tx_rises++;
      tx_prev <= tx_xr;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic start(input bit rx, input bit tx, input bit full, input logic [2:0] div);
      @(posedge core_clk);
      rx_full_reset <= rx & full; rx_mode_change <= rx & !full; rx_pll_divider <= div;
      tx_full_reset <= tx & full; tx_mode_change <= tx & !full; tx_pll_divider <= div;
      @(posedge core_clk);
      rx_full_reset <= 1'b0; rx_mode_change <= 1'b0;
      tx_full_reset <= 1'b0; tx_mode_change <= 1'b0;
   endtask : start
   task automatic wait_end(input bit tx, input bit fall, input string name);
      logic f0;
      @(posedge core_clk); #1;
      // a sequence started from failure keeps fail high, so only done ends it early
      f0 = tx ? tx_fail : rx_fail;
      if (fall) check(tx ? tx_done : rx_done, 1'b0);
      for (int i = 0; i < 3000; i++) begin
         if ((tx ? tx_done : rx_done) === 1'b1) break;
         if ((tx ? tx_fail : rx_fail) === 1'b1 && f0 !== 1'b1) break;
         @(posedge core_clk); #1;
      end
      check(tx ? (tx_done | tx_fail) : (rx_done | rx_fail), 1'b1);
      $display("test %s done", name);
   endtask : wait_end
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      wait_end(0, 0, "init rx"); wait_end(1, 0, "init tx");
      check(rx_done, 1'b1); check(tx_done, 1'b1); check(acc_q.size(), 0);
      start(1, 0, 0, 3'h2); wait_end(0, 1, "rx change");
      check(rx_done, 1'b1); check(acc_q.pop_front(), 4'h2);
      start(1, 1, 0, 3'h4); wait_end(0, 1, "both rx"); wait_end(1, 0, "both tx");
      check(tx_done, 1'b1); check(acc_q.pop_front(), 4'h4); check(acc_q.pop_front(), 4'hc);
      start(0, 1, 0, 3'h5); wait_end(1, 1, "bad divider");
      check(tx_fail, 1'b1); check(tx_code, 3'h3); check(acc_q.size(), 0);
      r = tx_rises;
      start(0, 1, 0, 3'h1); repeat (20) @(posedge core_clk); #1;
      check(tx_rises, r); check(tx_fail, 1'b1); check(tx_done, 1'b0);
      start(0, 1, 1, 3'h0); wait_end(1, 1, "tx recover");
      check(tx_done, 1'b1); check(tx_fail, 1'b0);
      rx_dead <= 1'b1;
      start(1, 0, 1, 3'h0); wait_end(0, 1, "rx reset timeout");
      check(rx_fail, 1'b1); check(rx_code, 3'h0);
      start(1, 0, 1, 3'h0); wait_end(0, 1, "rx reset fails again");
      check(rx_fail, 1'b1); check(rx_done, 1'b0);
      rx_dead <= 1'b0;
      start(1, 0, 1, 3'h0); wait_end(0, 1, "rx recover");
      check(rx_done, 1'b1); check(rx_fail, 1'b0);
      acc_dead <= 1'b1;
      start(1, 0, 0, 3'h1); wait_end(0, 1, "access timeout");
      check(rx_fail, 1'b1); check(rx_code, 3'h2);
      acc_dead <= 1'b0;
      start(1, 0, 1, 3'h0); wait_end(0, 1, "rx recover again");
      check(rx_done, 1'b1); check(rx_rate_count, 24'h00_0019);
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      $display("watchdog expired");
      complete_run();
   end
endmodule : sdisq_tb_top
`default_nettype wire
